/* File: hdl/gafm_pkg.sv */
package gafm_pkg;

	localparam int NUM_PORTS = 8;
	localparam int PORT_W = 8;

	// Port indices, A, C and D only
	localparam logic [2:0] PORT_A = 3'h0;
	localparam logic [2:0] PORT_C = 3'h2;
	localparam logic [2:0] PORT_D = 3'h3;

	// Directly addressable registers of each port
	localparam logic [1:0] REG_SUBREG_SELECT = 2'h0;
	localparam logic [1:0] REG_SUBREG_WINDOW = 2'h1;
	localparam logic [1:0] REG_INPUT_VALUE = 2'h2;
	localparam logic [1:0] REG_OUTPUT_VALUE = 2'h3;

	// Selector codes
	localparam logic [7:0] SUB_NONE = 8'h00;
	localparam logic [7:0] SUB_DIRECTION = 8'h01;
	localparam logic [7:0] SUB_PERIPH = 8'h02;
	localparam logic [7:0] SUB_OPEN_DRAIN = 8'h03;
	localparam logic [7:0] SUB_HIGH_DRIVE = 8'h04;
	localparam logic [7:0] SUB_WAKE = 8'h05;

	// Reset values
	localparam logic [7:0] SELECT_RST = 8'h00;
	localparam logic [7:0] DIRECTION_RST = 8'hff;
	localparam logic [7:0] PERIPH_RST = 8'h00;
	localparam logic [7:0] OPEN_DRAIN_RST = 8'h00;
	localparam logic [7:0] HIGH_DRIVE_RST = 8'h00;
	localparam logic [7:0] WAKE_RST = 8'h00;
	localparam logic [7:0] OUTPUT_RST = 8'h00;
	localparam logic [7:0] INPUT_RST = 8'h00;
	localparam logic [7:0] READ_NONE = 8'h00;
	localparam logic IDLE_LEVEL = 1'b1;

	// Pin positions of peripheral functions
	localparam int A_TIMER0_IN = 0;
	localparam int A_TIMER0_OUT = 1;
	localparam int A_UART0_DE = 2;
	localparam int A_UART0_CTS = 3;
	localparam int A_UART0_RX = 4;
	localparam int A_UART0_TX = 5;
	localparam int A_I2C_CLOCK = 6;
	localparam int A_I2C_DATA = 7;
	localparam int C_TIMER1_IN = 0;
	localparam int C_TIMER1_OUT = 1;
	localparam int C_SPI_SS = 2;
	localparam int C_SPI_SCK = 3;
	localparam int C_SPI_MOSI = 4;
	localparam int C_SPI_MISO = 5;
	localparam int C_TIMER2_IN = 6;
	localparam int C_TIMER2_OUT = 7;
	localparam int D_TIMER3_IN = 0;
	localparam int D_TIMER3_OUT = 1;
	localparam int D_UART1_DE = 3;
	localparam int D_UART1_RX = 4;
	localparam int D_UART1_TX = 5;
	localparam int D_UART1_CTS = 6;
	localparam int D_WDT_OSC = 7;

	// Pins with a peripheral function, per port (D low pair gated apart)
	localparam logic [7:0] ROUTED_MASK [NUM_PORTS] = '{
		8'hff, 8'h00, 8'hff, 8'hf8, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] TIMER3_MASK = 8'h03;
	// Pins forced open-drain while their peripheral owns them
	localparam logic [7:0] FORCED_OD_MASK [NUM_PORTS] = '{
		8'hc0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	// Interrupt-capable pins, and which of them use one selectable edge
	localparam logic [7:0] IRQ_CAP_MASK [NUM_PORTS] = '{
		8'hff, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] IRQ_SINGLE_MASK [NUM_PORTS] = '{
		8'hff, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};

	typedef struct packed {
		logic wr;
		logic rd;
		logic [2:0] port;
		logic [1:0] reg_sel;
		logic [7:0] wdata;
	} gafm_access_t;

	typedef struct packed {
		logic [7:0] data;
		logic [7:0] oe;
	} gafm_drive_t;

	typedef logic [NUM_PORTS-1:0][PORT_W-1:0] gafm_bus_t;

endpackage : gafm_pkg

/* File: hdl/gafm_edge_detect.sv */
module gafm_edge_detect
	import gafm_pkg::*;
#(
	parameter logic [7:0] CAP_MASK = 8'h00,
	parameter logic [7:0] SINGLE_MASK = 8'h00
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [7:0] pin_level,
	input wire logic [7:0] rising_sel,
	input wire logic [7:0] wake_enable,
	output logic [7:0] irq_pulse,
	output logic [7:0] wake_pulse
);

	logic [7:0] prev_reg;
	logic [7:0] irq_reg;
	logic [7:0] wake_reg;
	logic [7:0] rise;
	logic [7:0] fall;
	logic [7:0] chosen_edge;
	logic [7:0] any_edge;

	assign rise = pin_level & ~prev_reg;
	assign fall = ~pin_level & prev_reg;
	assign any_edge = rise | fall;
	assign chosen_edge = (rising_sel & rise) | (~rising_sel & fall);

	always_ff @(posedge core_clk) begin
		if (srst) begin
			prev_reg <= INPUT_RST;
			irq_reg <= 8'h00;
			wake_reg <= 8'h00;
		end else begin
			prev_reg <= pin_level;
			irq_reg <= CAP_MASK & ((SINGLE_MASK & chosen_edge) |
				(~SINGLE_MASK & any_edge));
			wake_reg <= wake_enable & any_edge;
		end
	end

	assign irq_pulse = irq_reg;
	assign wake_pulse = wake_reg;

endmodule : gafm_edge_detect

/* File: hdl/gafm_mux.sv */
// How it works
// - A pin owned by its peripheral takes direction from that peripheral.
// - Each port has a peripheral-select subregister, one bit per pin.
// - Port A bits 0-5: timer0 in/out, uart0 DE, CTS, receive, transmit.
// - Port A bits 6,7 carry I2C clock/data, forced open-drain while handed over.
// - Port C: timer1 in/out, SPI SS, SCK, MOSI, MISO, timer2 in/out.
// - Port D bits 0,1 carry timer3 in/out, absent in small package.
// - Port D bit 2 unrouted; bits 3-6 uart1 DE, receive, transmit, CTS.
// - Port D bit 7 outputs the watchdog oscillator clock.
// - Some pins interrupt on one selectable edge.
// - Other capable pins interrupt on both edges.
// - Four direct registers per port: select, window, input, output.
// - Window accesses go to the subregister named by the selector.
// - Five subregisters: direction, periph, open-drain, high drive, wake.
// - Selector 01h-05h decode; any other code makes window inert.
// - Direction 0 drives output value; 1 tri-states and samples pin.
module gafm_mux
	import gafm_pkg::*;
#(
	parameter logic HAS_TIMER3 = 1'b1
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire gafm_access_t reg_access,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire gafm_bus_t pin_in,
	output gafm_bus_t pin_out,
	output gafm_bus_t pin_oe,
	output gafm_bus_t pin_high_drive,
	input wire gafm_bus_t irq_rising_sel,
	output gafm_bus_t irq_pulse,
	output gafm_bus_t wake_pulse,
	input wire logic timer0_output,
	input wire logic timer1_output,
	input wire logic timer2_output,
	input wire logic timer3_output,
	input wire logic uart0_driver_enable,
	input wire logic uart0_transmit,
	input wire logic uart1_driver_enable,
	input wire logic uart1_transmit,
	input wire logic watchdog_osc_output,
	input wire logic i2c_clock_drive_low,
	input wire logic i2c_data_drive_low,
	input wire logic [3:0] spi_out,
	input wire logic [3:0] spi_oe,
	output logic timer0_input,
	output logic timer1_input,
	output logic timer2_input,
	output logic timer3_input,
	output logic uart0_clear_to_send,
	output logic uart0_receive,
	output logic uart1_receive,
	output logic uart1_clear_to_send,
	output logic i2c_clock_in,
	output logic i2c_data_in,
	output logic [3:0] spi_in
);

	////////////////////////////////////////////////////////////////////////
	function automatic logic reg_hit(gafm_access_t acc, int idx,
		logic [1:0] which);
		return (acc.port == idx[2:0]) && (acc.reg_sel == which);
	endfunction : reg_hit

	function automatic logic window_hit(gafm_access_t acc, int idx,
		logic [7:0] cur_sel, logic [7:0] code);
		return acc.wr && reg_hit(acc, idx, REG_SUBREG_WINDOW) &&
			(cur_sel == code);
	endfunction : window_hit

	////////////////////////////////////////////////////////////////////////
	gafm_bus_t sel_reg;
	gafm_bus_t dir_reg;
	gafm_bus_t periph_reg;
	gafm_bus_t od_reg;
	gafm_bus_t hd_reg;
	gafm_bus_t wake_en_reg;
	gafm_bus_t out_reg;
	gafm_bus_t in_reg;
	gafm_bus_t pin_out_reg;
	gafm_bus_t pin_oe_reg;
	gafm_bus_t owned;
	gafm_bus_t window_rd;
	gafm_drive_t drive [NUM_PORTS];
	logic [7:0] d_routed;
	logic [7:0] rdata_next;
	logic [7:0] reg_rdata_reg;
	logic reg_rvalid_reg;

	// Small package drops the timer3 pair
	assign d_routed = ROUTED_MASK[PORT_D] |
		(HAS_TIMER3 ? TIMER3_MASK : 8'h00);

	////////////////////////////////////////////////////////////////////////
	// Peripheral drive per pin; input-only functions leave oe low
	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			drive[p] = '0;
		end
		drive[PORT_A].data[A_TIMER0_OUT] = timer0_output;
		drive[PORT_A].oe[A_TIMER0_OUT] = 1'b1;
		drive[PORT_A].data[A_UART0_DE] = uart0_driver_enable;
		drive[PORT_A].oe[A_UART0_DE] = 1'b1;
		drive[PORT_A].data[A_UART0_TX] = uart0_transmit;
		drive[PORT_A].oe[A_UART0_TX] = 1'b1;
		drive[PORT_A].oe[A_I2C_CLOCK] = i2c_clock_drive_low;
		drive[PORT_A].oe[A_I2C_DATA] = i2c_data_drive_low;
		drive[PORT_C].data[C_TIMER1_OUT] = timer1_output;
		drive[PORT_C].oe[C_TIMER1_OUT] = 1'b1;
		drive[PORT_C].data[C_SPI_MISO:C_SPI_SS] = spi_out;
		drive[PORT_C].oe[C_SPI_MISO:C_SPI_SS] = spi_oe;
		drive[PORT_C].data[C_TIMER2_OUT] = timer2_output;
		drive[PORT_C].oe[C_TIMER2_OUT] = 1'b1;
		drive[PORT_D].data[D_TIMER3_OUT] = timer3_output;
		drive[PORT_D].oe[D_TIMER3_OUT] = 1'b1;
		drive[PORT_D].data[D_UART1_DE] = uart1_driver_enable;
		drive[PORT_D].oe[D_UART1_DE] = 1'b1;
		drive[PORT_D].data[D_UART1_TX] = uart1_transmit;
		drive[PORT_D].oe[D_UART1_TX] = 1'b1;
		drive[PORT_D].data[D_WDT_OSC] = watchdog_osc_output;
		drive[PORT_D].oe[D_WDT_OSC] = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	genvar gp;
	generate
		for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
			logic [7:0] routed;
			logic [7:0] gpio_oe;
			logic [7:0] alt_oe;
			logic [7:0] alt_data;
			logic [7:0] oe_next;
			logic [7:0] data_next;
			logic [7:0] sample_en;

			assign routed = (gp == PORT_D) ? d_routed : ROUTED_MASK[gp];
			// Unrouted select bits are stored but never hand over the pin
			assign owned[gp] = periph_reg[gp] & routed;
			// Open-drain drives only low
			assign gpio_oe = ~dir_reg[gp] &
				~(od_reg[gp] & out_reg[gp]);
			assign alt_oe = drive[gp].oe &
				~(FORCED_OD_MASK[gp] & drive[gp].data);
			assign alt_data = drive[gp].data & ~FORCED_OD_MASK[gp];
			assign oe_next = (owned[gp] & alt_oe) |
				(~owned[gp] & gpio_oe);
			assign data_next = (owned[gp] & alt_data) |
				(~owned[gp] & out_reg[gp]);
			assign sample_en = dir_reg[gp] | owned[gp];

			always_comb begin
				case (sel_reg[gp])
					SUB_DIRECTION: window_rd[gp] = dir_reg[gp];
					SUB_PERIPH: window_rd[gp] = periph_reg[gp];
					SUB_OPEN_DRAIN: window_rd[gp] = od_reg[gp];
					SUB_HIGH_DRIVE: window_rd[gp] = hd_reg[gp];
					SUB_WAKE: window_rd[gp] = wake_en_reg[gp];
					default: window_rd[gp] = READ_NONE;
				endcase
			end

			// Direct registers
			always_ff @(posedge core_clk) begin
				if (srst) begin
					sel_reg[gp] <= SELECT_RST;
					out_reg[gp] <= OUTPUT_RST;
				end else if (reg_access.wr) begin
					if (reg_hit(reg_access, gp, REG_SUBREG_SELECT)) begin
						sel_reg[gp] <= reg_access.wdata;
					end
					if (reg_hit(reg_access, gp, REG_OUTPUT_VALUE)) begin
						out_reg[gp] <= reg_access.wdata;
					end
				end
			end

			// Subregisters behind the window
			always_ff @(posedge core_clk) begin
				if (srst) begin
					dir_reg[gp] <= DIRECTION_RST;
					periph_reg[gp] <= PERIPH_RST;
					od_reg[gp] <= OPEN_DRAIN_RST;
					hd_reg[gp] <= HIGH_DRIVE_RST;
					wake_en_reg[gp] <= WAKE_RST;
				end else begin
					if (window_hit(reg_access, gp, sel_reg[gp],
						SUB_DIRECTION)) begin
						dir_reg[gp] <= reg_access.wdata;
					end
					if (window_hit(reg_access, gp, sel_reg[gp],
						SUB_PERIPH)) begin
						periph_reg[gp] <= reg_access.wdata;
					end
					if (window_hit(reg_access, gp, sel_reg[gp],
						SUB_OPEN_DRAIN)) begin
						od_reg[gp] <= reg_access.wdata;
					end
					if (window_hit(reg_access, gp, sel_reg[gp],
						SUB_HIGH_DRIVE)) begin
						hd_reg[gp] <= reg_access.wdata;
					end
					if (window_hit(reg_access, gp, sel_reg[gp],
						SUB_WAKE)) begin
						wake_en_reg[gp] <= reg_access.wdata;
					end
				end
			end

			// Pad drive and input capture
			always_ff @(posedge core_clk) begin
				if (srst) begin
					pin_oe_reg[gp] <= 8'h00;
					pin_out_reg[gp] <= OUTPUT_RST;
					in_reg[gp] <= INPUT_RST;
				end else begin
					pin_oe_reg[gp] <= oe_next;
					pin_out_reg[gp] <= data_next;
					in_reg[gp] <= (sample_en & pin_in[gp]) |
						(~sample_en & in_reg[gp]);
				end
			end

			gafm_edge_detect #(
				.CAP_MASK(IRQ_CAP_MASK[gp]),
				.SINGLE_MASK(IRQ_SINGLE_MASK[gp])
			) u_edge (
				.core_clk(core_clk),
				.srst(srst),
				.pin_level(pin_in[gp]),
				.rising_sel(irq_rising_sel[gp]),
				.wake_enable(wake_en_reg[gp]),
				.irq_pulse(irq_pulse[gp]),
				.wake_pulse(wake_pulse[gp])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Read path, one cycle latency
	always_comb begin
		case (reg_access.reg_sel)
			REG_SUBREG_SELECT: rdata_next = sel_reg[reg_access.port];
			REG_SUBREG_WINDOW: rdata_next = window_rd[reg_access.port];
			REG_INPUT_VALUE: rdata_next = in_reg[reg_access.port];
			REG_OUTPUT_VALUE: rdata_next = out_reg[reg_access.port];
			default: rdata_next = READ_NONE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			reg_rdata_reg <= READ_NONE;
			reg_rvalid_reg <= 1'b0;
		end else begin
			reg_rvalid_reg <= reg_access.rd;
			if (reg_access.rd) begin
				reg_rdata_reg <= rdata_next;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Peripheral inputs idle high unless the pin is handed over
	always_ff @(posedge core_clk) begin
		if (srst) begin
			timer0_input <= IDLE_LEVEL;
			uart0_clear_to_send <= IDLE_LEVEL;
			uart0_receive <= IDLE_LEVEL;
			i2c_clock_in <= IDLE_LEVEL;
			i2c_data_in <= IDLE_LEVEL;
			timer1_input <= IDLE_LEVEL;
			timer2_input <= IDLE_LEVEL;
			spi_in <= {4{IDLE_LEVEL}};
			timer3_input <= IDLE_LEVEL;
			uart1_receive <= IDLE_LEVEL;
			uart1_clear_to_send <= IDLE_LEVEL;
		end else begin
			timer0_input <= owned[PORT_A][A_TIMER0_IN] ?
				pin_in[PORT_A][A_TIMER0_IN] : IDLE_LEVEL;
			uart0_clear_to_send <= owned[PORT_A][A_UART0_CTS] ?
				pin_in[PORT_A][A_UART0_CTS] : IDLE_LEVEL;
			uart0_receive <= owned[PORT_A][A_UART0_RX] ?
				pin_in[PORT_A][A_UART0_RX] : IDLE_LEVEL;
			i2c_clock_in <= owned[PORT_A][A_I2C_CLOCK] ?
				pin_in[PORT_A][A_I2C_CLOCK] : IDLE_LEVEL;
			i2c_data_in <= owned[PORT_A][A_I2C_DATA] ?
				pin_in[PORT_A][A_I2C_DATA] : IDLE_LEVEL;
			timer1_input <= owned[PORT_C][C_TIMER1_IN] ?
				pin_in[PORT_C][C_TIMER1_IN] : IDLE_LEVEL;
			timer2_input <= owned[PORT_C][C_TIMER2_IN] ?
				pin_in[PORT_C][C_TIMER2_IN] : IDLE_LEVEL;
			spi_in <= (owned[PORT_C][C_SPI_MISO:C_SPI_SS] &
				pin_in[PORT_C][C_SPI_MISO:C_SPI_SS]) |
				~owned[PORT_C][C_SPI_MISO:C_SPI_SS];
			timer3_input <= owned[PORT_D][D_TIMER3_IN] ?
				pin_in[PORT_D][D_TIMER3_IN] : IDLE_LEVEL;
			uart1_receive <= owned[PORT_D][D_UART1_RX] ?
				pin_in[PORT_D][D_UART1_RX] : IDLE_LEVEL;
			uart1_clear_to_send <= owned[PORT_D][D_UART1_CTS] ?
				pin_in[PORT_D][D_UART1_CTS] : IDLE_LEVEL;
		end
	end

	assign reg_rdata = reg_rdata_reg;
	assign reg_rvalid = reg_rvalid_reg;
	assign pin_out = pin_out_reg;
	assign pin_oe = pin_oe_reg;
	assign pin_high_drive = hd_reg;

endmodule : gafm_mux

/* File: verification/gafm_checker.sv */
module gafm_checker
	import gafm_pkg::*;
(
	input wire logic core_clk,
	input wire logic srst,
	input wire gafm_access_t reg_access,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire gafm_bus_t pin_in,
	input wire gafm_bus_t pin_out,
	input wire gafm_bus_t pin_oe,
	input wire gafm_bus_t irq_rising_sel,
	input wire gafm_bus_t irq_pulse,
	input wire logic timer0_output,
	input wire logic i2c_clock_drive_low,
	input wire logic timer0_input
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] sel_a_reg;
	logic [7:0] af_a_reg;
	logic a_wr;
	logic a_rd_win;
	logic [7:0] a_now;
	logic [7:0] c_now;
	assign a_wr = reg_access.wr && reg_access.port == PORT_A;
	assign a_rd_win = reg_access.rd && !reg_access.wr &&
		reg_access.port == PORT_A && reg_access.reg_sel == REG_SUBREG_WINDOW;
	assign a_now = pin_in[PORT_A];
	assign c_now = pin_in[PORT_C];
	////////////////////////////////////////////////////////////////////////
	// Port A shadow only, to keep the checker small
	always_ff @(posedge core_clk) begin
		if (srst) begin
			sel_a_reg <= SELECT_RST;
			af_a_reg <= PERIPH_RST;
		end else if (a_wr && reg_access.reg_sel == REG_SUBREG_SELECT) begin
			sel_a_reg <= reg_access.wdata;
		end else if (a_wr && reg_access.reg_sel == REG_SUBREG_WINDOW &&
				sel_a_reg == SUB_PERIPH) begin
			af_a_reg <= reg_access.wdata;
		end
	end
	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);
	AST_RVALID: assert property (reg_access.rd |=> reg_rvalid)
		else $error("read not answered");
	AST_SEL_NONE: assert property (a_rd_win &&
		!(sel_a_reg inside {[8'h01:8'h05]}) |=> reg_rdata == READ_NONE)
		else $error("inert selector read nonzero");
	AST_AF_READ: assert property (a_rd_win && sel_a_reg == SUB_PERIPH
		|=> reg_rdata == $past(af_a_reg))
		else $error("periph select readback wrong");
	AST_TIMER0_OUT: assert property (!$past(srst) && $past(af_a_reg[1])
		|-> pin_oe[0][1] && pin_out[0][1] == $past(timer0_output))
		else $error("timer0 output pin wrong");
	AST_I2C_OD: assert property (!$past(srst) && $past(af_a_reg[6])
		|-> !pin_out[0][6] && pin_oe[0][6] == $past(i2c_clock_drive_low))
		else $error("i2c clock pin not open drain");
	AST_TIMER0_IN: assert property (!$past(srst) |-> timer0_input ==
		($past(af_a_reg[0]) ? $past(pin_in[0][0]) : 1'b1))
		else $error("timer0 input wrong");
	AST_IRQ_SINGLE: assert property (!$past(srst) && !$past(srst, 2)
		|-> irq_pulse[0] == (($past(a_now) ^ $past(a_now, 2)) &
		~($past(a_now) ^ $past(irq_rising_sel[0]))))
		else $error("port A edge interrupt wrong");
	AST_IRQ_ANY: assert property (!$past(srst) && !$past(srst, 2)
		|-> irq_pulse[2] == ($past(c_now) ^ $past(c_now, 2)))
		else $error("port C edge interrupt wrong");
	AST_RESET: assert property (@(posedge core_clk) disable iff (1'b0)
		srst |=> pin_oe == '0 && !reg_rvalid && timer0_input)
		else $error("reset state wrong");
	cover property (irq_pulse[0] != 8'h00);
	cover property (irq_pulse[2] != 8'h00);
	cover property (a_rd_win && sel_a_reg == SUB_PERIPH);
endmodule : gafm_checker

bind gafm_mux gafm_checker u_gafm_checker (
	.core_clk(core_clk), .srst(srst), .reg_access(reg_access),
	.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pin_in(pin_in),
	.pin_out(pin_out), .pin_oe(pin_oe), .irq_rising_sel(irq_rising_sel),
	.irq_pulse(irq_pulse), .timer0_output(timer0_output),
	.i2c_clock_drive_low(i2c_clock_drive_low), .timer0_input(timer0_input)
);

/* File: verification/gafm_periph_model.sv */
module gafm_periph_model
	import gafm_pkg::*;
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic hold,
	output logic [15:0] drive
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] lfsr_reg;
	logic [15:0] lfsr_next;
	// Busy peripherals; frozen only while the bench inspects pins
	assign lfsr_next = {lfsr_reg[14:0],
		lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
	always_ff @(posedge core_clk) begin
		if (srst) lfsr_reg <= 16'hace1;
		else if (!hold) lfsr_reg <= lfsr_next;
	end
	assign drive = lfsr_reg;
endmodule : gafm_periph_model

/* File: verification/tb_top.sv */
module tb_top
	import gafm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
`define CHECK(got, exp) \
	begin \
		total_checks++; \
		if ((got) !== (exp)) begin \
			miscompares++; \
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); \
		end \
	end
	int miscompares = 0;
	int total_checks = 0;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic hold = 1'b0;
	gafm_access_t reg_access = '0;
	gafm_bus_t pin_in = '0;
	gafm_bus_t irq_rising_sel = '0;
	logic [7:0] reg_rdata;
	logic reg_rvalid;
	gafm_bus_t pin_out, pin_oe, pin_high_drive, irq_pulse, wake_pulse;
	logic [15:0] drive;
	logic t0_in, t1_in, t2_in, t3_in, u0_cts, u0_rx, u1_rx, u1_cts;
	logic scl_in, sda_in;
	logic [3:0] spi_in;

	always #50 core_clk = ~core_clk;

	gafm_periph_model periph (.core_clk(core_clk), .srst(srst), .hold(hold),
		.drive(drive));
	gafm_mux dut (
		.core_clk(core_clk), .srst(srst), .reg_access(reg_access),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .pin_high_drive(pin_high_drive),
		.irq_rising_sel(irq_rising_sel), .irq_pulse(irq_pulse),
		.wake_pulse(wake_pulse), .timer0_output(drive[0]),
		.timer1_output(drive[1]), .timer2_output(drive[2]),
		.timer3_output(drive[3]), .uart0_driver_enable(drive[4]),
		.uart0_transmit(drive[5]), .uart1_driver_enable(drive[6]),
		.uart1_transmit(drive[7]), .watchdog_osc_output(drive[8]),
		.i2c_clock_drive_low(drive[9]), .i2c_data_drive_low(drive[10]),
		.spi_out(drive[13:10]), .spi_oe(drive[15:12]),
		.timer0_input(t0_in), .timer1_input(t1_in), .timer2_input(t2_in),
		.timer3_input(t3_in), .uart0_clear_to_send(u0_cts),
		.uart0_receive(u0_rx), .uart1_receive(u1_rx),
		.uart1_clear_to_send(u1_cts), .i2c_clock_in(scl_in),
		.i2c_data_in(sda_in), .spi_in(spi_in)
	);
	////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("checks=%0d mismatches=%0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : wrap_up

	task automatic wr_reg(input logic [2:0] p, input logic [1:0] s,
			input logic [7:0] d);
		@(posedge core_clk) reg_access <= '{1'b1, 1'b0, p, s, d};
		@(posedge core_clk) reg_access <= '0;
	endtask : wr_reg

	task automatic rd_reg(input logic [2:0] p, input logic [1:0] s,
			output logic [7:0] d);
		int n;
		@(posedge core_clk) reg_access <= '{1'b0, 1'b1, p, s, 8'h00};
		@(posedge core_clk) reg_access <= '0;
		#1;
		n = 0;
		while (reg_rvalid !== 1'b1 && n < 4) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		if (reg_rvalid !== 1'b1) begin
			miscompares++;
			wrap_up();
		end
		d = reg_rdata;
	endtask : rd_reg

	task automatic chk_sub(input logic [2:0] p, input logic [7:0] sub,
			input logic [7:0] exp);
		logic [7:0] d;
		wr_reg(p, REG_SUBREG_SELECT, sub);
		rd_reg(p, REG_SUBREG_WINDOW, d);
		`CHECK(d, exp)
	endtask : chk_sub

	// Pulses are gathered over a span so the exact cycle need not be guessed
	task automatic watch(input logic [2:0] p, input logic wake,
			output logic [7:0] acc, output int cnt);
		logic [7:0] v;
		acc = 8'h00;
		cnt = 0;
		repeat (6) begin
			@(negedge core_clk);
			v = wake ? wake_pulse[p] : irq_pulse[p];
			acc = acc | v;
			if (v != 8'h00) cnt++;
		end
	endtask : watch

	task automatic irq_case(input logic [2:0] p, input logic [7:0] v,
			input logic [7:0] exp);
		logic [7:0] acc;
		int cnt;
		@(posedge core_clk) pin_in[p] <= v;
		watch(p, 1'b0, acc, cnt);
		`CHECK({acc, cnt[3:0]}, {exp, 4'h1})
	endtask : irq_case
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset_values();
		logic [7:0] d;
		rd_reg(PORT_A, REG_SUBREG_SELECT, d);
		`CHECK(d, SELECT_RST)
		chk_sub(PORT_A, SUB_NONE, READ_NONE);
		chk_sub(PORT_A, SUB_DIRECTION, DIRECTION_RST);
		chk_sub(PORT_A, SUB_PERIPH, PERIPH_RST);
		chk_sub(PORT_A, SUB_OPEN_DRAIN, OPEN_DRAIN_RST);
		chk_sub(PORT_A, SUB_HIGH_DRIVE, HIGH_DRIVE_RST);
		chk_sub(PORT_A, SUB_WAKE, WAKE_RST);
	endtask : t_reset_values

	task automatic t_direction();
		logic [7:0] d;
		logic [7:0] acc;
		int cnt;
		wr_reg(3'h1, REG_SUBREG_SELECT, SUB_DIRECTION);
		wr_reg(3'h1, REG_SUBREG_WINDOW, 8'h0f);
		wr_reg(3'h1, REG_OUTPUT_VALUE, 8'ha5);
		@(posedge core_clk) pin_in[1] <= 8'h3c;
		wr_reg(3'h1, REG_SUBREG_SELECT, 8'h06);
		wr_reg(3'h1, REG_SUBREG_WINDOW, 8'hff);
		rd_reg(3'h1, REG_SUBREG_WINDOW, d);
		`CHECK(d, READ_NONE)
		chk_sub(3'h1, SUB_DIRECTION, 8'h0f);
		@(negedge core_clk);
		`CHECK(pin_oe[1], 8'hf0)
		`CHECK(pin_out[1] & 8'hf0, 8'ha0)
		rd_reg(3'h1, REG_INPUT_VALUE, d);
		`CHECK(d, 8'h0c)
		wr_reg(3'h1, REG_SUBREG_SELECT, SUB_HIGH_DRIVE);
		wr_reg(3'h1, REG_SUBREG_WINDOW, 8'h81);
		@(negedge core_clk);
		`CHECK(pin_high_drive[1], 8'h81)
		wr_reg(3'h1, REG_SUBREG_SELECT, SUB_WAKE);
		wr_reg(3'h1, REG_SUBREG_WINDOW, 8'h01);
		@(posedge core_clk) pin_in[1] <= 8'h3d;
		watch(3'h1, 1'b1, acc, cnt);
		`CHECK({acc, cnt[3:0]}, 12'h011)
	endtask : t_direction

	task automatic t_port_a();
		@(posedge core_clk) hold <= 1'b1;
		wr_reg(PORT_A, REG_SUBREG_SELECT, SUB_PERIPH);
		wr_reg(PORT_A, REG_SUBREG_WINDOW, 8'hff);
		@(posedge core_clk) pin_in[0] <= 8'h50;
		repeat (3) @(negedge core_clk);
		`CHECK({pin_out[0][5], pin_out[0][2:1]}, {drive[5:4], drive[0]})
		`CHECK({pin_oe[0][5:0]}, 6'h26)
		`CHECK({t0_in, u0_cts, u0_rx, scl_in, sda_in}, 5'b00110)
		`CHECK(pin_out[0][7:6], 2'b00)
		`CHECK(pin_oe[0][7:6], drive[10:9])
		`CHECK(pin_out[0][1], drive[0])
		wr_reg(PORT_A, REG_SUBREG_WINDOW, 8'h00);
		// Pads and peripheral inputs follow the select one edge later
		repeat (2) @(negedge core_clk);
		`CHECK({pin_oe[0], t0_in, u0_rx}, 10'h003)
	endtask : t_port_a

	task automatic t_port_cd();
		wr_reg(PORT_C, REG_SUBREG_SELECT, SUB_PERIPH);
		wr_reg(PORT_C, REG_SUBREG_WINDOW, 8'hff);
		wr_reg(PORT_D, REG_SUBREG_SELECT, SUB_PERIPH);
		wr_reg(PORT_D, REG_SUBREG_WINDOW, 8'hff);
		// Port D outputs everywhere, so only the handover lets its owned inputs follow the pins
		wr_reg(PORT_D, REG_SUBREG_SELECT, SUB_DIRECTION);
		wr_reg(PORT_D, REG_SUBREG_WINDOW, 8'h00);
		@(posedge core_clk) pin_in[2] <= 8'h24;
		@(posedge core_clk) pin_in[3] <= 8'h11;
		repeat (3) @(negedge core_clk);
		`CHECK({spi_in, t1_in, t2_in}, 6'h24)
		`CHECK(pin_oe[2][5:2], drive[15:12])
		`CHECK(pin_out[2][5:2] & drive[15:12], drive[13:10] & drive[15:12])
		`CHECK({pin_out[2][7], pin_out[2][1]}, drive[2:1])
		`CHECK({t3_in, u1_rx, u1_cts}, 3'b110)
		`CHECK({pin_out[3][5], pin_out[3][3]}, drive[7:6])
		`CHECK(pin_out[3][1], drive[3])
		`CHECK({pin_out[3][7], pin_oe[3][2]}, {drive[8], 1'b1})
		`CHECK(pin_oe[3][0], 1'b0)
		wr_reg(3'h4, REG_SUBREG_SELECT, SUB_PERIPH);
		wr_reg(3'h4, REG_SUBREG_WINDOW, 8'hff);
		wr_reg(3'h4, REG_SUBREG_SELECT, SUB_DIRECTION);
		wr_reg(3'h4, REG_SUBREG_WINDOW, 8'h00);
		wr_reg(3'h4, REG_OUTPUT_VALUE, 8'h5a);
		repeat (2) @(negedge core_clk);
		`CHECK({pin_oe[4], pin_out[4]}, 16'hff5a)
		@(posedge core_clk) hold <= 1'b0;
	endtask : t_port_cd

	task automatic t_irq();
		irq_case(PORT_A, 8'hff, 8'h0f);
		irq_case(PORT_A, 8'h00, 8'hf0);
		irq_case(PORT_C, 8'hdb, 8'hff);
		irq_case(PORT_D, 8'h00, 8'h01);
	endtask : t_irq
	////////////////////////////////////////////////////////////////////////
	initial begin
		irq_rising_sel[PORT_A] <= 8'h0f;
		irq_rising_sel[PORT_D] <= 8'hf0;
		repeat (6) @(posedge core_clk);
		srst <= 1'b0;
		t_reset_values();
		t_direction();
		t_port_a();
		t_port_cd();
		t_irq();
		wrap_up();
	end
endmodule : tb_top
